//--- rtl/esp_button.sv
// pushbutton synchroniser with press, click and hold detection
`timescale 1ns/10ps
`default_nettype none
module esp_button #(
	parameter int HOLD_TICKS = esp_pkg::HOLD_MS
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	input wire logic ms_tick,
	output logic press,
	output logic click,
	output logic hold
);
	import esp_pkg::*;
	logic sync1, sync2, last, held;
	logic [15:0] hold_ms;
	wire logic rise = sync2 && !last;
	wire logic fall = !sync2 && last;
	wire logic hold_hit = sync2 && !held && ms_tick && hold_ms == 16'(HOLD_TICKS - 1);
	// pin is asynchronous: two flops before anything reads it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			last <= 1'b0;
		end
		else
		begin
			sync1 <= pin;
			sync2 <= sync1;
			last <= sync2;
		end
	end
	// hold timer, restarts on every release
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !sync2)
		begin
			hold_ms <= 16'h0000;
			held <= 1'b0;
		end
		else if (hold_hit)
			held <= 1'b1;
		else if (ms_tick && !held)
			hold_ms <= hold_ms + 16'h0001;
	end
	// one-cycle events; a long hold never also counts as a click
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			press <= 1'b0;
			click <= 1'b0;
			hold <= 1'b0;
		end
		else
		begin
			press <= rise;
			click <= fall && !held;
			hold <= hold_hit;
		end
	end
endmodule // esp_button
`default_nettype wire

//--- rtl/esp_panel.sv
// front-panel lamps, display, pushbuttons and horn with an AXI4-Lite register port
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - locate active flashes all three lamps, overriding everything else.
// - healthy: monitor lamp flashes, power on, fault off.
// - enclosure fault: monitor flashes, power and fault on, error code shown.
// - power just applied: monitor flashes, power and fault off.
// - monitor failed: monitor lamp steady, power on, fault off.
// - lower rail bad: all status lamps off.
// - lower button click steps groups: number, loop, reporting, alarm, error.
// - upper button click steps sublevels within the current group.
// - default display is the enclosure number in decimal.
// - loop group shows bay one loop identifier in hex.
// - reporting group number shown as two decimal digit pairs.
// - alarm group offers enabled and disabled sublevel codes.
// - error group is reachable only while an error exists.
// - display flashes on editable or report items, steady otherwise.
// - upper button lamp lit until the newest error has been viewed.
// - lower button lamp lit exactly when alarm muted or disabled.
// - any error sounds the horn unless muted or disabled.
// - disabled alarm never sounds; display continues unaffected.
// - a new condition clears mute and sounds the horn again.
// - horn pattern follows the most severe active error class.
// - remind mode plays the pattern once about every thirty seconds.
// - holding lower button while errors exist toggles mute.
// - display returns home one minute after last press unless errors.
module esp_panel #(
	parameter int MS_TICK_CYC = esp_pkg::MS_CYC,
	parameter int FLASH_TICKS = esp_pkg::FLASH_HALF_MS,
	parameter int TIMEOUT_TICKS = esp_pkg::TIMEOUT_MS,
	parameter int REMIND_TICKS = esp_pkg::REMIND_MS,
	parameter int HOLD_TICKS = esp_pkg::HOLD_MS,
	parameter logic [63:0] PAT_ON = esp_pkg::PAT_ON_MS,
	parameter logic [63:0] PAT_OFF = esp_pkg::PAT_OFF_MS
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [esp_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [esp_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic btn_upper_pin,
	input wire logic btn_lower_pin,
	input wire logic rail5_ok,
	input wire logic rail12_ok,
	input wire logic encl_fault,
	input wire logic monitor_fail,
	input wire logic monitor_lamp_level,
	input wire logic power_settling,
	input wire logic [3:0] err_active,
	input wire logic err_new,
	input wire logic [4:0] encl_number,
	input wire logic [6:0] loop_id,
	input wire logic [11:0] report_group,
	output var esp_pkg::esp_lamps_t status_lamps,
	output var esp_pkg::esp_btn_lamps_t btn_lamps,
	output var esp_pkg::esp_disp_t segs,
	output logic horn
);
	import esp_pkg::*;

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [6:0] seg7(input logic [4:0] c);
		case (c)
			5'h00: seg7 = 7'h3F;
			5'h01: seg7 = 7'h06;
			5'h02: seg7 = 7'h5B;
			5'h03: seg7 = 7'h4F;
			5'h04: seg7 = 7'h66;
			5'h05: seg7 = 7'h6D;
			5'h06: seg7 = 7'h7D;
			5'h07: seg7 = 7'h07;
			5'h08: seg7 = 7'h7F;
			5'h09: seg7 = 7'h6F;
			CH_A: seg7 = 7'h77;
			5'h0B: seg7 = 7'h7C;
			5'h0C: seg7 = 7'h39;
			5'h0D: seg7 = 7'h5E;
			CH_E: seg7 = 7'h79;
			CH_F: seg7 = 7'h71;
			CH_N: seg7 = 7'h54;
			CH_L: seg7 = 7'h38;
			CH_I: seg7 = 7'h10;
			CH_R: seg7 = 7'h50;
			CH_G: seg7 = 7'h3D;
			CH_U: seg7 = 7'h1C;
			CH_O: seg7 = 7'h5C;
			default: seg7 = 7'h00;
		endcase
	endfunction

	// two decimal digits as character codes, tens first
	function automatic logic [9:0] dec2(input logic [6:0] v);
		logic [6:0] t;
		logic [6:0] o;
		t = v / 7'd10;
		o = v % 7'd10;
		dec2 = {1'b0, t[3:0], 1'b0, o[3:0]};
	endfunction

	// group order; error group only while an error is present
	function automatic esp_group_t next_grp(input esp_group_t g, input logic e);
		case (g)
			GRP_EN: next_grp = GRP_LI;
			GRP_LI: next_grp = GRP_RG;
			GRP_RG: next_grp = GRP_AU;
			GRP_AU: next_grp = e ? GRP_ER : GRP_EN;
			default: next_grp = GRP_EN;
		endcase
	endfunction

	// ---------------------------------------------
	// millisecond tick and flash phase
	// ---------------------------------------------
	logic [19:0] div_cnt;
	logic [15:0] flash_ms;
	logic flash_phase;
	wire logic ms_tick = div_cnt == 20'(MS_TICK_CYC - 1);
	wire logic flash_wrap = ms_tick && flash_ms == 16'(FLASH_TICKS - 1);
	// one divider feeds lamps and display so they blink together
	always_ff @(posedge aclk)
	begin
		if (!aresetn || ms_tick)
			div_cnt <= 20'h00000;
		else
			div_cnt <= div_cnt + 20'h00001;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || flash_wrap)
			flash_ms <= 16'h0000;
		else if (ms_tick)
			flash_ms <= flash_ms + 16'h0001;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flash_phase <= 1'b0;
		else if (flash_wrap)
			flash_phase <= !flash_phase;
	end

	// ---------------------------------------------
	// pushbuttons
	// ---------------------------------------------
	logic up_press, up_click, lo_press, lo_click, lo_hold;
	esp_button #(.HOLD_TICKS(HOLD_TICKS)) u_btn_upper (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(btn_upper_pin),
		.ms_tick(ms_tick),
		.press(up_press),
		.click(up_click),
		.hold()
	);
	esp_button #(.HOLD_TICKS(HOLD_TICKS)) u_btn_lower (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(btn_lower_pin),
		.ms_tick(ms_tick),
		.press(lo_press),
		.click(lo_click),
		.hold(lo_hold)
	);

	// ---------------------------------------------
	// display navigation and alarm state
	// ---------------------------------------------
	esp_group_t group;
	logic [1:0] sub;
	logic au_pending, alarm_en, muted, unviewed;
	logic [1:0] ctrl;
	logic [19:0] idle_ms;
	wire logic any_err = (|err_active) || encl_fault;
	wire logic au_edit = group == GRP_AU && sub != 2'h0;
	wire logic [1:0] sub_max = group == GRP_RG ? SUB_MAX_RG : SUB_MAX;
	wire logic [1:0] next_sub = sub == sub_max ? 2'h0 : sub + 2'h1;
	wire logic timeout_hit = ms_tick && idle_ms == 20'(TIMEOUT_TICKS - 1);
	wire logic go_home = (timeout_hit || group == GRP_ER) && !any_err;
	// idle timer since the last press of either button
	always_ff @(posedge aclk)
	begin
		if (!aresetn || up_press || lo_press)
			idle_ms <= 20'h00000;
		else if (ms_tick && idle_ms != 20'(TIMEOUT_TICKS))
			idle_ms <= idle_ms + 20'h00001;
	end
	// group and sublevel selection, alarm enable edit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			group <= GRP_EN;
			sub <= SUB_HOME;
			au_pending <= ALARM_EN_RST;
			alarm_en <= ALARM_EN_RST;
		end
		else if (err_new)
		begin
			group <= GRP_ER;
			sub <= 2'h0;
		end
		else if (go_home)
		begin
			group <= GRP_EN;
			sub <= SUB_HOME;
		end
		else if (lo_click && au_edit)
		begin
			alarm_en <= au_pending;
			sub <= 2'h0;
		end
		else if (lo_click)
		begin
			group <= next_grp(group, any_err);
			sub <= 2'h0;
		end
		else if (up_click && au_edit)
			au_pending <= !au_pending;
		else if (up_click)
		begin
			sub <= next_sub;
			au_pending <= alarm_en;
		end
	end
	// mute: hold toggles, any new condition cancels it
	always_ff @(posedge aclk)
	begin
		if (!aresetn || err_new)
			muted <= 1'b0;
		else if (lo_hold && muted)
			muted <= 1'b0;
		else if (lo_hold && any_err && alarm_en)
			muted <= 1'b1;
	end
	// unviewed error; a new error wins over viewing in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			unviewed <= 1'b0;
		else if (err_new)
			unviewed <= 1'b1;
		else if (group == GRP_ER && sub != 2'h0)
			unviewed <= 1'b0;
	end

	// ---------------------------------------------
	// horn pattern and remind
	// ---------------------------------------------
	logic [16:0] pat_ms;
	logic [15:0] rem_ms;
	logic rem_play;
	wire logic [1:0] sev = err_active[3] ? 2'h3 : err_active[2] ? 2'h2 :
		err_active[1] ? 2'h1 : 2'h0;
	wire logic [15:0] on_ms = PAT_ON[{sev, 4'h0} +: 16];
	wire logic [15:0] off_ms = PAT_OFF[{sev, 4'h0} +: 16];
	wire logic [16:0] pat_len = {1'b0, on_ms} + {1'b0, off_ms};
	wire logic pat_end = ms_tick && pat_ms >= pat_len - 17'h00001;
	wire logic pat_on = pat_ms < {1'b0, on_ms};
	wire logic rem_wrap = ms_tick && rem_ms == 16'(REMIND_TICKS - 1);
	wire logic remind = ctrl[CTRL_REMIND];
	wire logic next_horn = any_err && alarm_en && !muted && pat_on &&
		(!remind || rem_play);
	always_ff @(posedge aclk)
	begin
		if (!aresetn || err_new || (rem_wrap && remind) || pat_end)
			pat_ms <= 17'h00000;
		else if (ms_tick)
			pat_ms <= pat_ms + 17'h00001;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || rem_wrap)
			rem_ms <= 16'h0000;
		else if (ms_tick)
			rem_ms <= rem_ms + 16'h0001;
	end
	// one pattern per remind period; the restart wins over the end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rem_play <= 1'b0;
		else if (rem_wrap)
			rem_play <= 1'b1;
		else if (pat_end)
			rem_play <= 1'b0;
	end

	// ---------------------------------------------
	// lamps and display contents
	// ---------------------------------------------
	esp_lamps_t next_lamps;
	logic [9:0] chars;
	wire logic fp = flash_phase;
	wire logic [6:0] rg_hi = 7'(report_group / 12'd100);
	wire logic [6:0] rg_lo = 7'(report_group % 12'd100);
	wire logic disp_flash = sub != 2'h0 && group != GRP_EN;
	wire logic seg_on = !disp_flash || fp;
	// status lamp priority: locate, rail, monitor, power-up, fault
	always_comb
	begin
		if (ctrl[CTRL_LOCATE])
			next_lamps = {fp, fp, fp};
		else if (!rail5_ok)
			next_lamps = 3'b000;
		else if (monitor_fail)
			next_lamps = {monitor_lamp_level, 2'b10};
		else if (power_settling)
			next_lamps = {fp, 2'b00};
		else if (any_err || !rail12_ok)
			next_lamps = {fp, 2'b11};
		else
			next_lamps = {fp, 2'b10};
	end
	// two character codes for the current group and sublevel
	always_comb
	begin
		chars = {CH_BLANK, CH_BLANK};
		case (group)
			GRP_EN: chars = sub == 2'h0 ? {CH_E, CH_N} : dec2({2'b00, encl_number});
			GRP_LI: chars = sub == 2'h0 ? {CH_L, CH_I} :
				{2'b00, loop_id[6:4], 1'b0, loop_id[3:0]};
			GRP_RG: chars = sub == 2'h0 ? {CH_R, CH_G} :
				sub == 2'h1 ? dec2(rg_hi) : dec2(rg_lo);
			GRP_AU: chars = sub == 2'h0 ? {CH_A, CH_U} :
				au_pending ? {CH_O, CH_N} : {CH_O, CH_F};
			GRP_ER: chars = sub == 2'h0 ? {CH_E, CH_R} : {5'h00, 3'b000, sev};
			default: chars = {CH_BLANK, CH_BLANK};
		endcase
	end
	// registered pin outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_lamps <= 3'b000;
			btn_lamps <= 2'b00;
			segs <= 14'h0000;
			horn <= 1'b0;
		end
		else
		begin
			status_lamps <= next_lamps;
			btn_lamps <= {unviewed, muted || !alarm_en};
			segs <= seg_on ? {seg7(chars[9:5]), seg7(chars[4:0])} : 14'h0000;
			horn <= next_horn;
		end
	end

	// ---------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------
	logic aw_got, w_got, w_lane0;
	logic [ADDR_W-1:0] aw_addr;
	logic [1:0] w_bits;
	wire logic wr_fire = aw_got && w_got && !bvalid;
	wire logic wr_ctrl = aw_addr == ADDR_CTRL;
	wire logic wr_ok = wr_ctrl || aw_addr == ADDR_STAT;
	wire logic rd_ctrl = araddr == ADDR_CTRL;
	wire logic rd_stat = araddr == ADDR_STAT;
	wire logic [31:0] stat_word = {16'h0000, 3'b000, status_lamps, unviewed, horn,
		muted, alarm_en, remind, sub, group};
	wire logic [31:0] rd_word = rd_ctrl ? {30'h0, ctrl} :
		rd_stat ? stat_word : 32'h00000000;
	assign awready = !aw_got && !bvalid;
	assign wready = !w_got && !bvalid;
	assign arready = !rvalid;
	// address and data are taken independently, then answered together
	always_ff @(posedge aclk)
	begin
		if (!aresetn || wr_fire)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
		end
		else
		begin
			aw_got <= aw_got || (awvalid && awready);
			w_got <= w_got || (wvalid && wready);
		end
	end
	always_ff @(posedge aclk)
	begin
		if (awvalid && awready)
			aw_addr <= awaddr;
		if (wvalid && wready)
		begin
			w_bits <= wdata[1:0];
			w_lane0 <= wstrb[0];
		end
	end
	// control register; status word is read-only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl <= CTRL_RST;
		else if (wr_fire && wr_ctrl && w_lane0)
			ctrl <= w_bits;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ctrl || rd_stat ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_pair;
		aw_got && w_got && !bvalid;
	endsequence
	sequence s_step_en;
		lo_click && group == GRP_EN && !err_new && !go_home;
	endsequence
	a_locate_flash: assert property (ctrl[CTRL_LOCATE] |=>
		status_lamps == {3{$past(flash_phase)}}) else $error("locate lamps wrong");
	a_healthy_lamps: assert property (!ctrl[CTRL_LOCATE] && rail5_ok && rail12_ok &&
		!monitor_fail && !power_settling && !any_err |=>
		status_lamps == {$past(flash_phase), 2'b10}) else $error("healthy lamps wrong");
	a_rail_dark: assert property (!ctrl[CTRL_LOCATE] && !rail5_ok |=>
		status_lamps == 3'b000) else $error("lamps lit on bad rail");
	a_group_step: assert property (s_step_en |=> group == GRP_LI)
		else $error("group did not step");
	a_disabled_quiet: assert property (!alarm_en |=> !horn)
		else $error("horn while disabled");
	a_err_sounds: assert property (any_err && alarm_en && !muted && !remind &&
		pat_on |=> horn) else $error("horn silent on error");
	a_new_unmutes: assert property (err_new |=> !muted ##1 !btn_lamps.lower ||
		!alarm_en) else $error("mute kept on new error");
	a_unviewed_lamp: assert property (err_new |-> ##2 btn_lamps.upper)
		else $error("upper lamp not lit");
	a_timeout_home: assert property (timeout_hit && !any_err && !err_new |=>
		group == GRP_EN && sub == SUB_HOME) else $error("no return home");
	a_write_answer: assert property (s_wr_pair |=> bvalid ##0 $stable(ctrl) || wr_ctrl)
		else $error("write not answered");
	a_resp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
endmodule // esp_panel
`default_nettype wire

//--- rtl/esp_pkg.sv
// shared constants and types of the enclosure status panel
package esp_pkg;
	// ---------------------------------------------
	// timing, all derived from the 4 ns clock
	// ---------------------------------------------
	localparam int CLK_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS; // cycles per millisecond tick
	localparam int FLASH_HALF_MS = 250;
	localparam int TIMEOUT_MS = 60000; // one minute back to home display
	localparam int REMIND_MS = 30000;
	localparam int HOLD_MS = 1000;
	// horn on/off times per class, 16 bits each: [3] unrecoverable .. [0] information
	localparam logic [63:0] PAT_ON_MS = {16'h00C8, 16'h01F4, 16'h03E8, 16'h0064};
	localparam logic [63:0] PAT_OFF_MS = {16'h00C8, 16'h01F4, 16'h03E8, 16'h0F3C};
	// ---------------------------------------------
	// register map
	// ---------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int CTRL_LOCATE = 0;
	localparam int CTRL_REMIND = 1;
	localparam logic ALARM_EN_RST = 1'b1;
	// ---------------------------------------------
	// display sublevels and character codes
	// ---------------------------------------------
	localparam logic [1:0] SUB_HOME = 2'h1;
	localparam logic [1:0] SUB_MAX_RG = 2'h2;
	localparam logic [1:0] SUB_MAX = 2'h1;
	localparam logic [4:0] CH_A = 5'h0A;
	localparam logic [4:0] CH_E = 5'h0E;
	localparam logic [4:0] CH_F = 5'h0F;
	localparam logic [4:0] CH_N = 5'h10;
	localparam logic [4:0] CH_L = 5'h11;
	localparam logic [4:0] CH_I = 5'h12;
	localparam logic [4:0] CH_R = 5'h13;
	localparam logic [4:0] CH_G = 5'h14;
	localparam logic [4:0] CH_U = 5'h15;
	localparam logic [4:0] CH_O = 5'h16;
	localparam logic [4:0] CH_BLANK = 5'h1F;
	// ---------------------------------------------
	// types
	// ---------------------------------------------
	typedef enum logic [2:0] {
		GRP_EN = 3'b000,
		GRP_LI = 3'b001,
		GRP_RG = 3'b010,
		GRP_AU = 3'b011,
		GRP_ER = 3'b100
	} esp_group_t;
	typedef struct packed {
		logic monitor;
		logic power;
		logic fault;
	} esp_lamps_t;
	typedef struct packed {
		logic upper;
		logic lower;
	} esp_btn_lamps_t;
	typedef struct packed {
		logic [6:0] left;
		logic [6:0] right;
	} esp_disp_t;
endpackage

//--- testbench/enclosure_status_panel_tb_top.sv
// self-checking bench of the enclosure status panel
`timescale 1ns/10ps
`default_nettype none
module enclosure_status_panel_tb_top;
	import esp_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic awready, wready, arready, horn, err_new;
	logic [3:0] awaddr, araddr, wstrb, err_active;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic rail5_ok, rail12_ok, encl_fault, monitor_fail, monitor_lamp_level, power_settling;
	logic [4:0] encl_number;
	logic [6:0] loop_id;
	logic [11:0] report_group;
	wire btn_upper_pin, btn_lower_pin;
	esp_lamps_t status_lamps;
	esp_btn_lamps_t btn_lamps;
	esp_disp_t segs;
	int miscompares, num_checks, n, k;
	logic [7:0] k2 [4] = '{8'h41, 8'h42, 8'h43, 8'h40};
	// ---------------------------------------------
	// design and operator
	// ---------------------------------------------
	esp_panel #(.MS_TICK_CYC(4), .FLASH_TICKS(2), .TIMEOUT_TICKS(20), .REMIND_TICKS(1000),
		.HOLD_TICKS(3)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .btn_upper_pin, .btn_lower_pin, .rail5_ok, .rail12_ok,
		.encl_fault, .monitor_fail, .monitor_lamp_level, .power_settling, .err_active,
		.err_new, .encl_number, .loop_id, .report_group, .status_lamps, .btn_lamps, .segs,
		.horn);
	esp_operator u_op (.aclk, .btn_upper_pin, .btn_lower_pin);
	// 4 ns clock
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ---------------------------------------------
	// checks and bus tasks
	// ---------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tally_and_finish;
		if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task hang;
		chk("wait", 1, 0);
		tally_and_finish();
	endtask
	// both channels offered together, each released when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'b111};
		for (k = 0; k < 100 && !(bvalid === 1'b1 && bready); k++)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			rs = bresp;
		end
		bready <= 1'b0;
		if (k == 100) hang();
	endtask
	task automatic axr(input logic [3:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		for (k = 0; k < 100 && !(rvalid === 1'b1 && rready); k++)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			{rd, rs} = {rdata, rresp};
		end
		rready <= 1'b0;
		if (k == 100) hang();
	endtask
	// status word: mute, alarm enable, remind, sublevel, group
	task automatic chk_view(input logic [7:0] e);
		axr(ADDR_STAT);
		chk("view", {24'h0, e}, {24'h0, rd[7:0]});
	endtask
	task automatic chk_lamps(input logic [2:0] e, input logic [2:0] m);
		repeat (4) @(posedge aclk);
		chk("lamps", {29'h0, e & m}, {29'h0, status_lamps & m});
	endtask
	task automatic chk_btn(input logic [1:0] e);
		repeat (3) @(posedge aclk);
		chk("btn_lamps", {30'h0, e}, {30'h0, btn_lamps});
	endtask
	// segments in the lit phase, then whether they blink off within a flash period
	task automatic chk_segs(input logic [13:0] e, input logic f);
		for (n = 0; n < 40 && segs === 14'h0000; n++) @(posedge aclk);
		chk("segs", {18'h0, e}, {18'h0, segs});
		for (n = 0; n < 20 && segs !== 14'h0000; n++) @(posedge aclk);
		chk("flash", {31'h0, f}, {31'h0, n < 20});
	endtask
	task automatic wait_horn(input logic v, input int lim);
		for (n = 0; n < lim && horn !== v; n++) @(posedge aclk);
		if (n == lim) hang();
	endtask
	task automatic raise(input logic [3:0] a);
		@(posedge aclk);
		{err_active, err_new} <= {a, 1'b1};
		@(posedge aclk);
		err_new <= 1'b0;
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, err_new} = 7'h0;
		{awaddr, araddr, wstrb, err_active, wdata} = 48'h0;
		{rail5_ok, rail12_ok, encl_fault, monitor_fail, monitor_lamp_level} = 5'b11000;
		{power_settling, encl_number, loop_id, report_group} = {1'b0, 5'd7, 7'h2A, 12'd1234};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk_view(8'h48);
		chk_segs(14'h1F87, 1'b0);
		axr(ADDR_CTRL);
		chk("ctrl", 0, {rd[31:2], rs});
		axr(4'h8);
		chk("unmapped", 2, {rd[31:2], rs});
		axw(4'h8, 32'h3);
		chk("wr_resp", 2, {30'h0, rs});
		chk_lamps(3'b010, 3'b011);
		power_settling <= 1'b1;
		chk_lamps(3'b000, 3'b011);
		{power_settling, monitor_fail, monitor_lamp_level} <= 3'b011;
		chk_lamps(3'b110, 3'b111);
		{monitor_fail, rail5_ok} <= 2'b00;
		chk_lamps(3'b000, 3'b111);
		{rail5_ok, encl_fault} <= 2'b11;
		chk_lamps(3'b011, 3'b011);
		encl_fault <= 1'b0;
		foreach (k2[i])
		begin
			u_op.push(1'b1, 6);
			chk_view(k2[i]);
		end
		u_op.push(1'b1, 6);
		u_op.push(1'b0, 6);
		chk_view(8'h49);
		chk_segs(14'h2DF7, 1'b1);
		repeat (120) @(posedge aclk);
		chk_view(8'h48);
		repeat (2) u_op.push(1'b1, 6);
		u_op.push(1'b0, 6);
		chk_segs(14'h035B, 1'b1);
		u_op.push(1'b0, 6);
		chk_segs(14'h27E6, 1'b1);
		u_op.push(1'b1, 6);
		repeat (2) u_op.push(1'b0, 6);
		u_op.push(1'b1, 6);
		chk_view(8'h03);
		chk_btn(2'b01);
		raise(4'b0100);
		k = 0;
		for (n = 0; n < 200; n++) @(posedge aclk) if (horn !== 1'b0) k++;
		chk("horn_off", 0, k);
		chk_view(8'h04);
		chk_btn(2'b11);
		repeat (4) u_op.push(1'b1, 6);
		repeat (2) u_op.push(1'b0, 6);
		u_op.push(1'b1, 6);
		chk_view(8'h43);
		wait_horn(1'b1, 900);
		chk_btn(2'b10);
		u_op.push(1'b1, 30);
		chk_view(8'hC3);
		chk("horn", 0, {31'h0, horn});
		raise(4'b0100);
		wait_horn(1'b1, 40);
		chk_view(8'h44);
		u_op.push(1'b0, 6);
		chk_btn(2'b00);
		raise(4'b1001);
		wait_horn(1'b1, 40);
		wait_horn(1'b0, 5000);
		chk("on_time", 1, {31'h0, n >= 796 && n <= 804});
		// remind: one 200 ms burst per 1000 ms period, silent in between
		axw(ADDR_CTRL, 32'h2);
		wait_horn(1'b0, 5000);
		wait_horn(1'b1, 5000);
		wait_horn(1'b0, 5000);
		chk("remind_on", 1, {31'h0, n >= 796 && n <= 804});
		wait_horn(1'b1, 5000);
		chk("remind_gap", 1, {31'h0, n >= 3196 && n <= 3204});
		axw(ADDR_CTRL, 32'h1);
		repeat (3) @(posedge aclk);
		for (n = 0; n < 40; n++) @(posedge aclk) chk("locate", 1, {31'h0,
			status_lamps === 3'b000 || status_lamps === 3'b111});
		tally_and_finish();
	end
endmodule // enclosure_status_panel_tb_top
`default_nettype wire

//--- testbench/esp_operator.sv
// operator model that presses and releases the two panel pushbuttons
`timescale 1ns/10ps
`default_nettype none
module esp_operator (
	input wire logic aclk,
	output logic btn_upper_pin,
	output logic btn_lower_pin
);
	// a released button reads as not pressed, never floating
	initial
	begin
		btn_upper_pin = 1'b0;
		btn_lower_pin = 1'b0;
	end
	// short press is a click, long press a hold; then settle the synchronisers
	task automatic push(input logic lower, input int cyc);
		@(posedge aclk);
		if (lower) btn_lower_pin <= 1'b1;
		else btn_upper_pin <= 1'b1;
		repeat (cyc) @(posedge aclk);
		btn_lower_pin <= 1'b0;
		btn_upper_pin <= 1'b0;
		repeat (14) @(posedge aclk);
	endtask
endmodule // esp_operator
`default_nettype wire
